// ---- hw/modem_serial_port.sv ----
`timescale 1ns/10ps
//
// Contract
// - baud divisor here drives only the local port, no peer rate involved.
// - format code 0..5 selects 8N1,7E1,7O1,8N2,8E1,8O1.
// - format code resets to 0, eight bits no parity one stop.
// - bus-protocol mode resets to 0, disabled.
// - writing 1 to the mode bit enables bus-protocol mode.
// - in bus-protocol mode packet repeat is 3 or more.
// - flow control 0 none, 1 on rts line, 2 on dtr line.
module modem_serial_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd_pin,
  input wire logic hs_in_pin,
  output logic txd_pin,
  output logic rts_out,
  output logic dtr_out,
  output logic [3:0] repeat_out,
  output logic modbus_out
);
  ////////////////////////////////////////////////////////////////////////
  // configuration registers
  serial_cfg_pkg::cfg_s cfg_q, cfg_d;
  logic [15:0] baud_q, baud_d;
  logic perr_q, perr_d, ovf_q, ovf_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic rx_s1_q, rx_s2_q, hs_s1_q, hs_s2_q;
  logic rts_q, dtr_q;
  logic acc, wr, rd, hit;
  logic [3:0] rep_w;
  serial_cfg_pkg::frame_s frame;

  // fifo and engine links
  logic txf_in_ready, txf_out_valid, eng_tx_ready, tx_pop;
  logic [7:0] txf_out_data;
  logic rxf_in_ready, rxf_out_valid, rx_pop;
  logic [7:0] rxf_out_data;
  logic eng_strobe, eng_err, eng_tx_out;
  logic [7:0] eng_data;
  logic tx_push, hs_ok;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign repeat_out = cfg_q.repeat_cnt;
  assign modbus_out = cfg_q.modbus;
  assign rts_out = rts_q;
  assign dtr_out = dtr_q;

  ////////////////////////////////////////////////////////////////////////
  // apb decode, one wait state: answer in the second cycle of the access phase
  always_comb begin
    acc = psel && penable && !pready_q;
    wr = acc && pwrite;
    rd = acc && !pwrite;
    hit = (paddr == serial_cfg_pkg::ctrl_off) ||
          (paddr == serial_cfg_pkg::baud_off) ||
          (paddr == serial_cfg_pkg::txd_off) ||
          (paddr == serial_cfg_pkg::rxd_off) ||
          (paddr == serial_cfg_pkg::stat_off);
    frame = serial_cfg_pkg::decode_fmt(cfg_q.fmt);
    tx_push = wr && paddr == serial_cfg_pkg::txd_off;
    rx_pop = rd && paddr == serial_cfg_pkg::rxd_off;
  end

  // register writes and status
  always_comb begin
    cfg_d = cfg_q;
    baud_d = baud_q;
    perr_d = perr_q;
    ovf_d = ovf_q;
    rep_w = pwdata[serial_cfg_pkg::repeat_lsb +: 4];
    if (wr && paddr == serial_cfg_pkg::ctrl_off) begin
      cfg_d.fmt = (pwdata[serial_cfg_pkg::fmt_lsb +: 3] > 3'h5) ?
                  serial_cfg_pkg::fmt_rst :
                  pwdata[serial_cfg_pkg::fmt_lsb +: 3];
      cfg_d.modbus = pwdata[serial_cfg_pkg::modbus_bit];
      cfg_d.flow = (pwdata[serial_cfg_pkg::flow_lsb +: 2] == 2'h3) ?
                   serial_cfg_pkg::flow_none :
                   pwdata[serial_cfg_pkg::flow_lsb +: 2];
      cfg_d.repeat_cnt = (pwdata[serial_cfg_pkg::modbus_bit] &&
                          rep_w < serial_cfg_pkg::repeat_min) ?
                         serial_cfg_pkg::repeat_min : rep_w;
    end
    if (wr && paddr == serial_cfg_pkg::baud_off) begin
      baud_d = pwdata[15:0];
    end
    // sticky flags, write one clears, a new event wins
    if (wr && paddr == serial_cfg_pkg::stat_off) begin
      if (pwdata[0]) perr_d = 1'b0;
      if (pwdata[1]) ovf_d = 1'b0;
    end
    if (eng_strobe && eng_err) perr_d = 1'b1;
    if (eng_strobe && !rxf_in_ready) ovf_d = 1'b1;
  end

  // read mux and bus answer
  always_comb begin
    prdata_d = 32'h0000_0000;
    pready_d = acc;
    pslverr_d = acc && !hit;
    if (rd) begin
      unique case (paddr)
        serial_cfg_pkg::ctrl_off: prdata_d = {16'h0000,
          cfg_q.repeat_cnt, 2'h0, cfg_q.flow, 3'h0, cfg_q.modbus,
          1'b0, cfg_q.fmt};
        serial_cfg_pkg::baud_off: prdata_d = {16'h0000, baud_q};
        serial_cfg_pkg::rxd_off: prdata_d = {24'h000000, rxf_out_data};
        serial_cfg_pkg::stat_off: prdata_d = {26'h0, hs_s2_q,
          rxf_out_valid, txf_in_ready, eng_tx_ready, ovf_q, perr_q};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // handshake: peer line gates transmit, our line shows receive room
  always_comb begin
    hs_ok = (cfg_q.flow == serial_cfg_pkg::flow_none) || hs_s2_q;
    tx_pop = txf_out_valid && eng_tx_ready && hs_ok;
  end

  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= '{repeat_cnt: serial_cfg_pkg::repeat_rst,
                 flow: serial_cfg_pkg::flow_rst,
                 modbus: serial_cfg_pkg::modbus_rst,
                 fmt: serial_cfg_pkg::fmt_rst};
      baud_q <= serial_cfg_pkg::baud_rst;
      perr_q <= 1'b0;
      ovf_q <= 1'b0;
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      hs_s1_q <= 1'b0;
      hs_s2_q <= 1'b0;
      rts_q <= 1'b0;
      dtr_q <= 1'b0;
    end else if (clk_en) begin
      cfg_q <= cfg_d;
      baud_q <= baud_d;
      perr_q <= perr_d;
      ovf_q <= ovf_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      rx_s1_q <= rxd_pin;
      rx_s2_q <= rx_s1_q;
      hs_s1_q <= hs_in_pin;
      hs_s2_q <= hs_s1_q;
      rts_q <= (cfg_q.flow == serial_cfg_pkg::flow_rts) && rxf_in_ready;
      dtr_q <= (cfg_q.flow == serial_cfg_pkg::flow_dtr) && rxf_in_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data path
  sync_fifo #(.width(8), .depth(serial_cfg_pkg::fifo_depth)) tx_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .en(clk_en),
    .in_valid(tx_push),
    .in_ready(txf_in_ready),
    .in_data(pwdata[7:0]),
    .out_valid(txf_out_valid),
    .out_ready(tx_pop),
    .out_data(txf_out_data)
  );

  sync_fifo #(.width(8), .depth(serial_cfg_pkg::fifo_depth)) rx_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .en(clk_en),
    .in_valid(eng_strobe),
    .in_ready(rxf_in_ready),
    .in_data(eng_data),
    .out_valid(rxf_out_valid),
    .out_ready(rx_pop),
    .out_data(rxf_out_data)
  );

  serial_engine engine (
    .pclk(pclk),
    .presetn(presetn),
    .en(clk_en),
    .baud_div(baud_q),
    .frame(frame),
    .tx_valid(tx_pop),
    .tx_ready(eng_tx_ready),
    .tx_data(txf_out_data),
    .rx_in(rx_s2_q),
    .tx_out(eng_tx_out),
    .rx_strobe(eng_strobe),
    .rx_data(eng_data),
    .rx_err(eng_err)
  );

  assign txd_pin = eng_tx_out;

  ////////////////////////////////////////////////////////////////////////
  // checks
  fmt_reset_a: assert property (@(posedge pclk)
    $rose(presetn) |-> cfg_q.fmt == 3'h0)
    else $error("format not 0 after reset");
  modbus_reset_a: assert property (@(posedge pclk)
    $rose(presetn) |-> !cfg_q.modbus)
    else $error("bus mode on after reset");
  modbus_repeat_a: assert property (@(posedge pclk)
    disable iff (!presetn) cfg_q.modbus |-> cfg_q.repeat_cnt >= 4'h3)
    else $error("repeat below 3 in bus mode");
  modbus_enable_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    (clk_en && wr && paddr == 8'h00 && pwdata[4]) |=> cfg_q.modbus)
    else $error("bus mode not enabled");
  fmt_legal_a: assert property (@(posedge pclk)
    disable iff (!presetn) cfg_q.fmt <= 3'h5)
    else $error("illegal format code");
  flow_lines_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    cfg_q.flow == 2'h0 |=> !rts_q && !dtr_q)
    else $error("handshake line driven with no flow control");
  parity_flag_a: assert property (@(posedge pclk)
    disable iff (!presetn) (clk_en && eng_strobe && eng_err) |=> perr_q)
    else $error("parity error not flagged");
  baud_apply_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    (clk_en && wr && paddr == 8'h04) |=> baud_q == $past(pwdata[15:0]))
    else $error("baud divisor not applied");
endmodule // modem_serial_port

// ---- pkg/serial_cfg_pkg.sv ----
package serial_cfg_pkg;

  // register byte offsets
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] baud_off = 8'h04;
  localparam logic [7:0] txd_off = 8'h08;
  localparam logic [7:0] rxd_off = 8'h0C;
  localparam logic [7:0] stat_off = 8'h10;

  // reset values
  localparam logic [2:0] fmt_rst = 3'h0;
  localparam logic modbus_rst = 1'b0;
  localparam logic [1:0] flow_rst = 2'h0;
  localparam logic [3:0] repeat_rst = 4'h3;
  localparam logic [15:0] baud_rst = 16'h0006;

  // control field positions
  localparam int fmt_lsb = 0;
  localparam int modbus_bit = 4;
  localparam int flow_lsb = 8;
  localparam int repeat_lsb = 12;

  // flow control choices
  localparam logic [1:0] flow_none = 2'h0;
  localparam logic [1:0] flow_rts = 2'h1;
  localparam logic [1:0] flow_dtr = 2'h2;

  // least master packet repeat in bus mode
  localparam logic [3:0] repeat_min = 4'h3;

  // fifo depth
  localparam int fifo_depth = 16;

  typedef struct packed {
    logic [3:0] repeat_cnt;
    logic [1:0] flow;
    logic modbus;
    logic [2:0] fmt;
  } cfg_s;

  typedef struct packed {
    logic [3:0] nbits;
    logic par_en;
    logic par_odd;
    logic two_stop;
  } frame_s;

  // decode of the six way character format selection
  function automatic frame_s decode_fmt(input logic [2:0] f);
    frame_s r;
    r = '{nbits: 4'h8, par_en: 1'b0, par_odd: 1'b0, two_stop: 1'b0};
    case (f)
      3'h1: r = '{nbits: 4'h7, par_en: 1'b1, par_odd: 1'b0, two_stop: 1'b0};
      3'h2: r = '{nbits: 4'h7, par_en: 1'b1, par_odd: 1'b1, two_stop: 1'b0};
      3'h3: r = '{nbits: 4'h8, par_en: 1'b0, par_odd: 1'b0, two_stop: 1'b1};
      3'h4: r = '{nbits: 4'h8, par_en: 1'b1, par_odd: 1'b0, two_stop: 1'b0};
      3'h5: r = '{nbits: 4'h8, par_en: 1'b1, par_odd: 1'b1, two_stop: 1'b0};
      default: r = '{nbits: 4'h8, par_en: 1'b0, par_odd: 1'b0,
                     two_stop: 1'b0};
    endcase
    return r;
  endfunction

  // parity over the active data bits
  function automatic logic par_of(input logic [7:0] d, input frame_s f);
    logic p;
    p = ^d[6:0];
    if (f.nbits == 4'h8) begin
      p = p ^ d[7];
    end
    return p ^ f.par_odd;
  endfunction

endpackage

// ---- hw/sync_fifo.sv ----
`timescale 1ns/10ps
module sync_fifo #(
  parameter int width = 8,
  parameter int depth = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [width-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [width-1:0] out_data
);
  localparam int aw = $clog2(depth);

  logic [width-1:0] mem [depth];
  logic [aw:0] wp_q, wp_d, rp_q, rp_d;
  logic [width-1:0] rd_q;
  logic push, pop, full, empty;

  // pointer compare
  always_comb begin
    full = (wp_q[aw] != rp_q[aw]) && (wp_q[aw-1:0] == rp_q[aw-1:0]);
    empty = (wp_q == rp_q);
    in_ready = !full;
    out_valid = !empty;
    out_data = rd_q; // head word held in a register
    push = en && in_valid && !full;
    pop = en && out_ready && !empty;
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
  end

  // read and write pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  // storage write and registered head word, bypass when the slot is new
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wp_q[aw-1:0]] <= in_data;
    end
    if (push && wp_q[aw-1:0] == rp_d[aw-1:0]) begin
      rd_q <= in_data;
    end else begin
      rd_q <= mem[rp_d[aw-1:0]];
    end
  end

  // never push while full
  fifo_full_a: assert property (@(posedge pclk) disable iff (!presetn)
    full |-> !push) else $error("fifo pushed while full");
endmodule // sync_fifo

// ---- hw/serial_engine.sv ----
`timescale 1ns/10ps
module serial_engine (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic [15:0] baud_div,
  input wire serial_cfg_pkg::frame_s frame,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic rx_in,
  output logic tx_out,
  output logic rx_strobe,
  output logic [7:0] rx_data,
  output logic rx_err
);
  typedef enum logic [3:0] {
    idle = 4'b0001, start = 4'b0010, data = 4'b0100, tail = 4'b1000
  } ph_e;

  ph_e tst_q, tst_d, rst_q, rst_d;
  logic [15:0] tcnt_q, tcnt_d, rcnt_q, rcnt_d;
  logic [3:0] tbit_q, tbit_d, rbit_q, rbit_d;
  logic [7:0] tsh_q, tsh_d, rsh_q, rsh_d;
  logic tout_q, tout_d, rerr_q, rerr_d, rstb_d, rdone_q;
  logic [7:0] rdat_q, rdat_d;
  logic tail_len;

  assign tx_ready = (tst_q == idle);
  assign tx_out = tout_q;
  assign rx_strobe = rdone_q;
  assign rx_data = rdat_q;
  assign rx_err = rerr_q;

  // transmit sequencer, parity generated on the fly
  always_comb begin
    tst_d = tst_q;
    tcnt_d = tcnt_q;
    tbit_d = tbit_q;
    tsh_d = tsh_q;
    tout_d = tout_q;
    tail_len = frame.par_en | frame.two_stop;
    unique case (tst_q)
      idle: begin
        tout_d = 1'b1;
        if (tx_valid) begin
          tst_d = start;
          tsh_d = tx_data;
          tcnt_d = baud_div;
          tout_d = 1'b0;
        end
      end
      start, data, tail: begin
        if (tcnt_q != 16'h0000) begin
          tcnt_d = tcnt_q - 16'h0001;
        end else begin
          tcnt_d = baud_div;
          if (tst_q == start) begin
            tst_d = data;
            tbit_d = 4'h0;
            tout_d = tsh_q[0];
          end else if (tst_q == data) begin
            tbit_d = tbit_q + 4'h1;
            if (tbit_q + 4'h1 == frame.nbits) begin
              tst_d = tail;
              tbit_d = 4'h0;
              tout_d = frame.par_en ? serial_cfg_pkg::par_of(tsh_q, frame)
                                    : 1'b1;
            end else begin
              tout_d = tsh_q[tbit_q[2:0] + 3'h1];
            end
          end else begin
            tbit_d = tbit_q + 4'h1;
            tout_d = 1'b1;
            if (tbit_q == {3'h0, tail_len}) begin
              tst_d = idle;
            end
          end
        end
      end
      default: tst_d = idle;
    endcase
  end

  // receive sequencer, mid-bit sampling, checks parity and stop
  always_comb begin
    rst_d = rst_q;
    rcnt_d = rcnt_q;
    rbit_d = rbit_q;
    rsh_d = rsh_q;
    rerr_d = rerr_q;
    rdat_d = rdat_q;
    rstb_d = 1'b0;
    unique case (rst_q)
      idle: begin
        if (!rx_in) begin
          rst_d = start;
          rcnt_d = {1'b0, baud_div[15:1]};
        end
      end
      start, data, tail: begin
        if (rcnt_q != 16'h0000) begin
          rcnt_d = rcnt_q - 16'h0001;
        end else begin
          rcnt_d = baud_div;
          if (rst_q == start) begin
            rst_d = rx_in ? idle : data;
            rbit_d = 4'h0;
            rsh_d = 8'h00;
            rerr_d = 1'b0;
          end else if (rst_q == data) begin
            rsh_d[rbit_q[2:0]] = rx_in;
            rbit_d = rbit_q + 4'h1;
            if (rbit_q + 4'h1 == frame.nbits) begin
              rst_d = tail;
              rbit_d = 4'h0;
            end
          end else begin
            rbit_d = rbit_q + 4'h1;
            if (frame.par_en && rbit_q == 4'h0) begin
              if (rx_in != serial_cfg_pkg::par_of(rsh_q, frame)) begin
                rerr_d = 1'b1;
              end
            end else begin
              if (!rx_in) begin
                rerr_d = 1'b1;
              end
              if (rbit_q == {3'h0, frame.par_en | frame.two_stop}) begin
                rst_d = idle;
                rdat_d = rsh_q;
                rstb_d = 1'b1;
                rcnt_d = 16'h0000;
              end
            end
          end
        end
      end
      default: rst_d = idle;
    endcase
  end

  // state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tst_q <= idle;
      rst_q <= idle;
      tcnt_q <= '0;
      rcnt_q <= '0;
      tbit_q <= '0;
      rbit_q <= '0;
      tsh_q <= '0;
      rsh_q <= '0;
      tout_q <= 1'b1;
      rerr_q <= 1'b0;
      rdat_q <= '0;
      rdone_q <= 1'b0;
    end else if (en) begin
      tst_q <= tst_d;
      rst_q <= rst_d;
      tcnt_q <= tcnt_d;
      rcnt_q <= rcnt_d;
      tbit_q <= tbit_d;
      rbit_q <= rbit_d;
      tsh_q <= tsh_d;
      rsh_q <= rsh_d;
      tout_q <= tout_d;
      rerr_q <= rerr_d;
      rdat_q <= rdat_d;
      rdone_q <= rstb_d;
    end else begin
      rdone_q <= 1'b0;
    end
  end

  // line idles high between characters
  tx_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tst_q == idle && $past(tst_q) == idle) |-> tout_q)
    else $error("tx line low while idle");
endmodule // serial_engine

// ---- sim/instr_uart.sv ----
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// behavioural uart of the attached instrument
module instr_uart (
  input wire logic clk,
  input wire logic txd,
  output logic rxd,
  output logic hs
);
  int bit_cyc = 7;

  // idle mark level, peer allowed to send
  initial begin
    rxd = 1'b1;
    hs = 1'b1;
  end

  // handshake towards the port, high = may send
  task automatic hold(input logic v);
    hs <= v;
  endtask

  // format code to frame shape
  task automatic shape(input logic [2:0] f, output int nb, output logic pe,
                       output logic po, output logic s2);
    nb = (f == 3'h1 || f == 3'h2) ? 7 : 8;
    pe = f == 3'h1 || f == 3'h2 || f == 3'h4 || f == 3'h5;
    po = f == 3'h2 || f == 3'h5;
    s2 = f == 3'h3;
  endtask

  // one bit time on the line
  task automatic tbit(input logic b);
    rxd <= b;
    repeat (bit_cyc) @(posedge clk);
  endtask

  // send one character, parity spoiled on request
  task automatic send(input logic [2:0] f, input logic [7:0] d,
                      input logic bad);
    int nb;
    logic pe, po, s2, p;
    shape(f, nb, pe, po, s2);
    @(posedge clk);
    tbit(1'b0);
    p = po ^ bad;
    for (int i = 0; i < nb; i++) begin
      tbit(d[i]);
      p = p ^ d[i];
    end
    if (pe) tbit(p);
    tbit(1'b1);
    if (s2) tbit(1'b1);
  endtask

  // take one character, ok low on bad framing or parity
  task automatic recv(input logic [2:0] f, output logic [7:0] d,
                      output logic ok);
    int nb, k;
    logic pe, po, s2, p;
    shape(f, nb, pe, po, s2);
    d = 8'h00;
    ok = 1'b0;
    k = 0;
    while (txd !== 1'b0 && k < 4000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 4000) return;
    repeat (bit_cyc / 2) @(posedge clk);
    ok = txd === 1'b0;
    p = po;
    for (int i = 0; i < nb; i++) begin
      repeat (bit_cyc) @(posedge clk);
      d[i] = txd;
      p = p ^ txd;
    end
    if (pe) begin
      repeat (bit_cyc) @(posedge clk);
      ok = ok & (txd === p);
    end
    repeat (bit_cyc) @(posedge clk);
    ok = ok & (txd === 1'b1);
    if (s2) begin
      repeat (bit_cyc) @(posedge clk);
      ok = ok & (txd === 1'b1);
    end
  endtask
endmodule // instr_uart

// ---- sim/modem_serial_port_config_tb.sv ----
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module modem_serial_port_config_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, rxd_pin, hs_in_pin, txd_pin;
  logic rts_out, dtr_out, modbus_out;
  logic [3:0] repeat_out;
  int fail_count = 0;
  int checks = 0;
  typedef struct packed {
    logic [31:0] w;
    logic [31:0] r;
    logic [3:0] rep;
    logic mb;
    logic rts;
    logic dtr;
  } row_s;
  row_s rows[8] = '{
    '{32'h3001, 32'h3001, 4'h3, 1'b0, 1'b0, 1'b0},
    '{32'h3006, 32'h3000, 4'h3, 1'b0, 1'b0, 1'b0},
    '{32'h3105, 32'h3105, 4'h3, 1'b0, 1'b1, 1'b0},
    '{32'h3204, 32'h3204, 4'h3, 1'b0, 1'b0, 1'b1},
    '{32'h3303, 32'h3003, 4'h3, 1'b0, 1'b0, 1'b0},
    '{32'h1010, 32'h3010, 4'h3, 1'b1, 1'b0, 1'b0},
    '{32'h5010, 32'h5010, 4'h5, 1'b1, 1'b0, 1'b0},
    '{32'h5002, 32'h5002, 4'h5, 1'b0, 1'b0, 1'b0}};

  // 250 MHz clock
  always #2 pclk = ~pclk;

  modem_serial_port modem_serial_port_i (.pclk(pclk), .presetn(presetn),
    .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd_pin(rxd_pin), .hs_in_pin(hs_in_pin),
    .txd_pin(txd_pin), .rts_out(rts_out), .dtr_out(dtr_out),
    .repeat_out(repeat_out), .modbus_out(modbus_out));

  instr_uart instr_uart_i (.clk(pclk), .txd(txd_pin), .rxd(rxd_pin),
    .hs(hs_in_pin));

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      fail_count++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdv(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask

  // poll a status bit until it takes the wanted value
  task automatic waitst(input int b, input logic v);
    logic [31:0] r;
    int k;
    k = 0;
    do begin
      rdv(serial_cfg_pkg::stat_off, r);
      k++;
    end while (r[b] !== v && k < 200);
    chk(r[b], v);
    if (k >= 200) summarize();
  endtask

  // take a character from the port and compare it
  task automatic rx_char(input logic [2:0] f, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    instr_uart_i.recv(f, d, ok);
    chk(ok, 1'b1);
    chk(d, exp);
    if (ok !== 1'b1) summarize();
  endtask

  // watchdog
  initial begin
    repeat (100000) @(posedge pclk);
    fail_count++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [31:0] r;
    logic e, ok;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk({txd_pin, rts_out, dtr_out, modbus_out}, 4'h8);
    chk(repeat_out, 4'h3);
    rdv(serial_cfg_pkg::ctrl_off, r);
    chk(r, 32'h3000);
    rdv(serial_cfg_pkg::baud_off, r);
    chk(r, 32'h6);
    // configuration rows
    foreach (rows[i]) begin
      wr(serial_cfg_pkg::ctrl_off, rows[i].w);
      rdv(serial_cfg_pkg::ctrl_off, r);
      chk(r, rows[i].r);
      chk({repeat_out, modbus_out}, {rows[i].rep, rows[i].mb});
      chk({rts_out, dtr_out}, {rows[i].rts, rows[i].dtr});
    end
    apb(1'b0, 8'h14, 32'h0, r, e);
    chk(e, 1'b1);
    // transmit in every format
    for (int f = 0; f < 6; f++) begin
      wr(serial_cfg_pkg::ctrl_off, 32'h3000 | f);
      wr(serial_cfg_pkg::txd_off, 32'hB6 ^ f);
      rx_char(f[2:0], (8'hB6 ^ f[7:0]) & ((f == 1 || f == 2) ? 8'h7F : 8'hFF));
    end
    // receive good, seven bit and spoiled parity
    wr(serial_cfg_pkg::ctrl_off, 32'h3004);
    instr_uart_i.send(3'h4, 8'hA5, 1'b0);
    waitst(4, 1'b1);
    rdv(serial_cfg_pkg::rxd_off, r);
    chk(r[7:0], 8'hA5);
    wr(serial_cfg_pkg::ctrl_off, 32'h3001);
    instr_uart_i.send(3'h1, 8'hC3, 1'b0);
    waitst(4, 1'b1);
    rdv(serial_cfg_pkg::rxd_off, r);
    chk(r[7:0], 8'h43);
    instr_uart_i.send(3'h1, 8'h5A, 1'b1);
    waitst(0, 1'b1);
    wr(serial_cfg_pkg::stat_off, 32'h1);
    rdv(serial_cfg_pkg::stat_off, r);
    chk(r[0], 1'b0);
    // handshake holds transmit back
    wr(serial_cfg_pkg::ctrl_off, 32'h3100);
    instr_uart_i.hold(1'b0);
    wr(serial_cfg_pkg::txd_off, 32'h3C);
    ok = 1'b1;
    repeat (40) begin
      @(posedge pclk);
      ok = ok & (txd_pin === 1'b1);
    end
    chk(ok, 1'b1);
    instr_uart_i.hold(1'b1);
    rx_char(3'h0, 8'h3C);
    // local rate only
    wr(serial_cfg_pkg::baud_off, 32'h3);
    instr_uart_i.bit_cyc = 4;
    wr(serial_cfg_pkg::ctrl_off, 32'h3000);
    wr(serial_cfg_pkg::txd_off, 32'h96);
    rx_char(3'h0, 8'h96);
    // fill transmit fifo at a slow rate, then check the engine is busy
    wr(serial_cfg_pkg::baud_off, 32'hFFFF);
    for (int i = 0; i < 18; i++) wr(serial_cfg_pkg::txd_off, i);
    rdv(serial_cfg_pkg::stat_off, r);
    chk(r[2], 1'b0);
    // reset in mid run
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdv(serial_cfg_pkg::ctrl_off, r);
    chk(r, 32'h3000);
    rdv(serial_cfg_pkg::stat_off, r);
    chk(r[2], 1'b1);
    summarize();
  end
endmodule // modem_serial_port_config_tb
